// ===== hdl/tls_pkg.sv
// constants and types shared by the torque limit selector
package tls_pkg;
  localparam int LimW  = 16;
  localparam int IdxW  = 18;
  localparam int ModeW = 3;

  // register indices; byte address is four times the index
  localparam logic [IdxW-1:0] IdxFirstLim  = 18'h03013;
  localparam logic [IdxW-1:0] IdxMethodSel = 18'h03521;
  localparam logic [IdxW-1:0] IdxSecondLim = 18'h03522;
  localparam logic [IdxW-1:0] IdxNetFwdLim = 18'h03525;
  localparam logic [IdxW-1:0] IdxNetRevLim = 18'h03526;
  localparam logic [IdxW-1:0] IdxPosLim    = 18'h060E0;
  localparam logic [IdxW-1:0] IdxNegLim    = 18'h060E1;
  localparam logic [IdxW-1:0] IdxControl   = 18'h00100;
  localparam logic [IdxW-1:0] IdxStatus    = 18'h00101;
  localparam logic [IdxW-1:0] IdxFwdActive = 18'h00102;
  localparam logic [IdxW-1:0] IdxRevActive = 18'h00103;

  // control register fields
  localparam int CtrlNetFwdBit  = 0;
  localparam int CtrlNetRevBit  = 1;
  localparam int CtrlServoOnBit = 2;
  localparam int CtrlModeLsb    = 4;

  // status register fields
  localparam int StatActiveBit = 0;
  localparam int StatReqFwdBit = 1;
  localparam int StatReqRevBit = 2;

  // limits are in percent of rated torque
  localparam logic [LimW-1:0] LimitCeilPct = 16'h012C;
  localparam logic [LimW-1:0] SelLegalMax  = 16'h0007;
  localparam logic [31:0]     RegZero      = 32'h0000_0000;
  localparam logic [1:0]      AlignZero    = 2'h0;

  typedef enum logic [2:0] {
    SelFirstA = 3'h0,
    SelFirstB = 3'h1,
    SelSplit  = 3'h2,
    SelSwap   = 3'h3,
    SelMinAll = 3'h4,
    SelMinReq = 3'h5,
    SelNetReq = 3'h6,
    SelObjReq = 3'h7
  } tls_sel_t;

  typedef enum logic [ModeW-1:0] {
    ModeNone  = 3'h0,
    ModePos   = 3'h1,
    ModeSpeed = 3'h2,
    ModeTrq   = 3'h3,
    ModeFull  = 3'h4
  } tls_mode_t;
endpackage

// ===== hdl/tls_lim_if.sv
// limit objects and selection result between top and selector
interface tls_lim_if;
  logic [tls_pkg::LimW-1:0] firstLim;
  logic [tls_pkg::LimW-1:0] secondLim;
  logic [tls_pkg::LimW-1:0] netFwdLim;
  logic [tls_pkg::LimW-1:0] netRevLim;
  logic [tls_pkg::LimW-1:0] posLim;
  logic [tls_pkg::LimW-1:0] negLim;
  tls_pkg::tls_sel_t        sel;
  logic                     active;
  logic                     reqFwd;
  logic                     reqRev;
  logic [tls_pkg::LimW-1:0] fwdLim;
  logic [tls_pkg::LimW-1:0] revLim;

  modport cfg (output firstLim, secondLim, netFwdLim, netRevLim, posLim,
               negLim, sel, active, reqFwd, reqRev,
               input fwdLim, revLim);
  modport pick (input firstLim, secondLim, netFwdLim, netRevLim, posLim,
                negLim, sel, active, reqFwd, reqRev,
                output fwdLim, revLim);
endinterface

// ===== hdl/tls_limit_mux.sv
// per-direction torque limit selection
module tls_limit_mux (
  tls_lim_if.pick lim
);
  localparam int LimW = tls_pkg::LimW;

  function automatic logic [LimW-1:0] minOf(
    input logic [LimW-1:0] a,
    input logic [LimW-1:0] b
  );
    minOf = (a < b) ? a : b;
  endfunction

  function automatic logic [LimW-1:0] pickLim(
    input tls_pkg::tls_sel_t sel,
    input logic              req,
    input logic [LimW-1:0]   own,
    input logic [LimW-1:0]   first,
    input logic [LimW-1:0]   second,
    input logic [LimW-1:0]   net,
    input logic [LimW-1:0]   comb
  );
    unique case (sel)
      tls_pkg::SelFirstA: pickLim = first;            // RULE6
      tls_pkg::SelFirstB: pickLim = first;            // RULE6
      tls_pkg::SelSplit:  pickLim = own;              // RULE6
      tls_pkg::SelSwap:   pickLim = req ? second : first; // RULE7
      tls_pkg::SelMinAll: pickLim = comb;             // RULE8
      tls_pkg::SelMinReq: pickLim = req ? comb : own; // RULE8
      tls_pkg::SelNetReq: pickLim = req ? net : comb; // RULE9
      tls_pkg::SelObjReq: pickLim = req ? own : net;  // RULE9
    endcase
  endfunction

  logic [LimW-1:0] ownObj  [2];
  logic [LimW-1:0] netObj  [2];
  logic [LimW-1:0] combObj [2];
  logic [LimW-1:0] dirLim  [2];
  logic            dirReq  [2];

  assign ownObj[0]  = lim.firstLim;
  assign ownObj[1]  = lim.secondLim;
  assign netObj[0]  = lim.netFwdLim;
  assign netObj[1]  = lim.netRevLim;
  assign combObj[0] = minOf(lim.posLim, lim.firstLim);  // RULE10
  assign combObj[1] = minOf(lim.negLim, lim.secondLim); // RULE11
  assign dirReq[0]  = lim.reqFwd;
  assign dirReq[1]  = lim.reqRev;

  // index 0 is forward, 1 is reverse
  for (genvar d = 0; d < 2; d++) begin : g_dir
    assign dirLim[d] = lim.active                                   // RULE2
      ? pickLim(lim.sel, dirReq[d], ownObj[d], lim.firstLim,
                lim.secondLim, netObj[d], combObj[d])
      : lim.firstLim;
  end

  assign lim.fwdLim = dirLim[0]; // RULE1
  assign lim.revLim = dirLim[1]; // RULE1
endmodule

// ===== hdl/tls_top.sv
// torque limit selector with apb registers and torque clamp
//
// How it works
// RULE1: separate forward and reverse torque limits
// RULE2: switching only with servo on, valid mode
// RULE3: selector register picks the switching method
// RULE4: forward request is pin or network command
// RULE5: reverse request is pin or network command
// RULE6: selector 0,1 first; 2 first/second split
// RULE7: selector 3 second when requested, else first
// RULE8: selector 4 minimum; 5 minimum when requested
// RULE9: selector 6 network/minimum; 7 object/network
// RULE10: forward minimum of positive and first limit
// RULE11: reverse minimum of negative and second limit
// RULE12: limits 0 to 300 percent, reset maximum
// RULE13: lower ceiling for some drive/motor pairings
// RULE14: clamp torque command to selected limit
//
// Added by the designer: the APB interface to the registers.
module tls_top #(
  parameter int                         AddrW    = 20,
  parameter logic [tls_pkg::LimW-1:0]   MaxLimit = tls_pkg::LimitCeilPct
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [AddrW-1:0]         paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     fwdExtLimitIn,
  input  wire logic                     revExtLimitIn,
  input  wire logic [tls_pkg::LimW-1:0] torqueCmd,
  output logic      [tls_pkg::LimW-1:0] torqueOut
);
  localparam int LimW = tls_pkg::LimW;
  localparam int IdxW = tls_pkg::IdxW;

  function automatic logic isMapped(input logic [IdxW-1:0] idx);
    isMapped = idx inside {tls_pkg::IdxFirstLim, tls_pkg::IdxMethodSel,
                           tls_pkg::IdxSecondLim, tls_pkg::IdxNetFwdLim,
                           tls_pkg::IdxNetRevLim, tls_pkg::IdxPosLim,
                           tls_pkg::IdxNegLim, tls_pkg::IdxControl,
                           tls_pkg::IdxStatus, tls_pkg::IdxFwdActive,
                           tls_pkg::IdxRevActive};
  endfunction

  function automatic logic isReadOnly(input logic [IdxW-1:0] idx);
    isReadOnly = idx inside {tls_pkg::IdxStatus, tls_pkg::IdxFwdActive,
                             tls_pkg::IdxRevActive};
  endfunction

  function automatic logic [LimW-1:0] capLim(input logic [LimW-1:0] v);
    capLim = (v > MaxLimit) ? MaxLimit : v; // RULE12 RULE13
  endfunction

  tls_lim_if lim ();

  logic [LimW-1:0]  firstLim_q;
  logic [LimW-1:0]  secondLim_q;
  logic [LimW-1:0]  netFwdLim_q;
  logic [LimW-1:0]  netRevLim_q;
  logic [LimW-1:0]  posLim_q;
  logic [LimW-1:0]  negLim_q;
  logic [2:0]       sel_q;
  logic [7:0]       ctrl_q;
  logic [31:0]      prdata_q;
  logic [LimW-1:0]  torqueOut_q;
  logic [LimW-1:0]  torqueOut_d;
  logic [31:0]      rdValue;

  // bus decode
  wire [IdxW-1:0]   regIdx    = IdxW'(paddr[AddrW-1:2]);
  wire              aligned   = paddr[1:0] == tls_pkg::AlignZero;
  wire              setup     = psel && !penable;
  wire              access    = psel && penable;
  wire              mapped    = aligned && isMapped(regIdx);
  wire              selBad    = pwdata[LimW-1:0] > tls_pkg::SelLegalMax;
  wire              hitSel    = regIdx == tls_pkg::IdxMethodSel;
  wire              wrBad     = pwrite && (isReadOnly(regIdx)
                                || (hitSel && selBad));
  wire              accErr    = !mapped || wrBad;
  wire              wrEn      = access && pwrite && !accErr;
  wire [LimW-1:0]   wrLim     = capLim(pwdata[LimW-1:0]);

  wire              wrFirst   = wrEn && regIdx == tls_pkg::IdxFirstLim;
  wire              wrSecond  = wrEn && regIdx == tls_pkg::IdxSecondLim;
  wire              wrNetFwd  = wrEn && regIdx == tls_pkg::IdxNetFwdLim;
  wire              wrNetRev  = wrEn && regIdx == tls_pkg::IdxNetRevLim;
  wire              wrPos     = wrEn && regIdx == tls_pkg::IdxPosLim;
  wire              wrNeg     = wrEn && regIdx == tls_pkg::IdxNegLim;
  wire              wrSel     = wrEn && hitSel;
  wire              wrCtrl    = wrEn && regIdx == tls_pkg::IdxControl;

  // control decode
  wire              netFwdCmd = ctrl_q[tls_pkg::CtrlNetFwdBit];
  wire              netRevCmd = ctrl_q[tls_pkg::CtrlNetRevBit];
  wire              servoOn   = ctrl_q[tls_pkg::CtrlServoOnBit];
  wire [2:0]        modeCode  = ctrl_q[tls_pkg::CtrlModeLsb +: 3];
  wire              modeOk    = modeCode inside {tls_pkg::ModePos,
                                  tls_pkg::ModeSpeed, tls_pkg::ModeTrq,
                                  tls_pkg::ModeFull};
  wire              active    = servoOn && modeOk;         // RULE2
  wire              reqFwd    = fwdExtLimitIn || netFwdCmd; // RULE4
  wire              reqRev    = revExtLimitIn || netRevCmd; // RULE5

  assign lim.firstLim  = firstLim_q;
  assign lim.secondLim = secondLim_q;
  assign lim.netFwdLim = netFwdLim_q;
  assign lim.netRevLim = netRevLim_q;
  assign lim.posLim    = posLim_q;
  assign lim.negLim    = negLim_q;
  assign lim.sel       = tls_pkg::tls_sel_t'(sel_q); // RULE3
  assign lim.active    = active;
  assign lim.reqFwd    = reqFwd;
  assign lim.reqRev    = reqRev;

  tls_limit_mux u_mux (
    .lim (lim.pick)
  );

  // torque clamp, negative values compared by magnitude
  wire              cmdNeg    = torqueCmd[LimW-1];
  wire [LimW-1:0]   cmdMag    = cmdNeg ? LimW'(-torqueCmd) : torqueCmd;
  wire              overFwd   = !cmdNeg && cmdMag > lim.fwdLim;
  wire              overRev   = cmdNeg && cmdMag > lim.revLim;

  always_comb begin
    if (overFwd) begin
      torqueOut_d = lim.fwdLim;          // RULE14 RULE1
    end else if (overRev) begin
      torqueOut_d = LimW'(-lim.revLim);  // RULE14 RULE1
    end else begin
      torqueOut_d = torqueCmd;
    end
  end

  // read mux
  always_comb begin
    rdValue = tls_pkg::RegZero;
    unique case (regIdx)
      tls_pkg::IdxFirstLim:  rdValue[LimW-1:0] = firstLim_q;
      tls_pkg::IdxMethodSel: rdValue[2:0]      = sel_q;
      tls_pkg::IdxSecondLim: rdValue[LimW-1:0] = secondLim_q;
      tls_pkg::IdxNetFwdLim: rdValue[LimW-1:0] = netFwdLim_q;
      tls_pkg::IdxNetRevLim: rdValue[LimW-1:0] = netRevLim_q;
      tls_pkg::IdxPosLim:    rdValue[LimW-1:0] = posLim_q;
      tls_pkg::IdxNegLim:    rdValue[LimW-1:0] = negLim_q;
      tls_pkg::IdxControl:   rdValue[7:0]      = ctrl_q;
      tls_pkg::IdxStatus: begin
        rdValue[tls_pkg::StatActiveBit] = active;
        rdValue[tls_pkg::StatReqFwdBit] = reqFwd;
        rdValue[tls_pkg::StatReqRevBit] = reqRev;
      end
      tls_pkg::IdxFwdActive: rdValue[LimW-1:0] = lim.fwdLim;
      tls_pkg::IdxRevActive: rdValue[LimW-1:0] = lim.revLim;
      default:               rdValue = tls_pkg::RegZero;
    endcase
  end

  // limit objects, reset to the ceiling
  always_ff @(posedge clk) begin
    if (rst) begin
      firstLim_q  <= MaxLimit; // RULE12
      secondLim_q <= MaxLimit;
      netFwdLim_q <= MaxLimit;
      netRevLim_q <= MaxLimit;
      posLim_q    <= MaxLimit;
      negLim_q    <= MaxLimit;
    end else begin
      if (wrFirst)  firstLim_q  <= wrLim;
      if (wrSecond) secondLim_q <= wrLim;
      if (wrNetFwd) netFwdLim_q <= wrLim;
      if (wrNetRev) netRevLim_q <= wrLim;
      if (wrPos)    posLim_q    <= wrLim;
      if (wrNeg)    negLim_q    <= wrLim;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q  <= tls_pkg::SelFirstA;
      ctrl_q <= '0;
    end else begin
      if (wrSel)  sel_q  <= pwdata[2:0]; // RULE3
      if (wrCtrl) ctrl_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q    <= tls_pkg::RegZero;
      torqueOut_q <= '0;
    end else begin
      if (setup) prdata_q <= rdValue;
      torqueOut_q <= torqueOut_d;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = 1'b1;
  assign pslverr   = access && accErr;
  assign torqueOut = torqueOut_q;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  fwd_request_a: assert property ( // RULE4
      lim.reqFwd == (fwdExtLimitIn || ctrl_q[tls_pkg::CtrlNetFwdBit]))
    else $error("forward request mismatch");
  rev_request_a: assert property ( // RULE5
      lim.reqRev == (revExtLimitIn || ctrl_q[tls_pkg::CtrlNetRevBit]))
    else $error("reverse request mismatch");
  reset_ceiling_a: assert property ($past(rst) |-> // RULE12
      firstLim_q == MaxLimit && secondLim_q == MaxLimit
      && netFwdLim_q == MaxLimit && netRevLim_q == MaxLimit
      && posLim_q == MaxLimit && negLim_q == MaxLimit)
    else $error("limit reset value wrong");
  inactive_first_a: assert property (!active |->                        // RULE2
      lim.fwdLim == firstLim_q && lim.revLim == firstLim_q)
    else $error("inactive limit not first object");
  sel_low_a: assert property (active && sel_q <= 3'h1 |->               // RULE6
      lim.fwdLim == firstLim_q && lim.revLim == firstLim_q)
    else $error("selector 0/1 limit wrong");
  sel_split_a: assert property (active && sel_q == 3'h2 |->             // RULE6
      lim.fwdLim == firstLim_q && lim.revLim == secondLim_q)
    else $error("selector 2 limit wrong");
  sel_swap_a: assert property (active && sel_q == 3'h3 |->              // RULE7
      lim.fwdLim == (reqFwd ? secondLim_q : firstLim_q)
      && lim.revLim == (reqRev ? secondLim_q : firstLim_q))
    else $error("selector 3 limit wrong");
  fwd_min_a: assert property (active && sel_q == 3'h4 |->               // RULE10
      lim.fwdLim <= posLim_q && lim.fwdLim <= firstLim_q
      && (lim.fwdLim == posLim_q || lim.fwdLim == firstLim_q))
    else $error("forward minimum wrong");
  rev_min_a: assert property (active && sel_q == 3'h4 |->               // RULE11
      lim.revLim <= negLim_q && lim.revLim <= secondLim_q
      && (lim.revLim == negLim_q || lim.revLim == secondLim_q))
    else $error("reverse minimum wrong");
  min_req_a: assert property (active && sel_q == 3'h5 && !reqFwd |->    // RULE8
      lim.fwdLim == firstLim_q)
    else $error("selector 5 idle forward wrong");
  net_req_a: assert property (active && sel_q == 3'h6 && reqRev |->     // RULE9
      lim.revLim == netRevLim_q)
    else $error("selector 6 reverse wrong");
  obj_req_a: assert property (active && sel_q == 3'h7 && !reqFwd |->    // RULE9
      lim.fwdLim == netFwdLim_q)
    else $error("selector 7 forward wrong");
  min_rev_idle_a: assert property ( // RULE8
      active && lim.sel == tls_pkg::SelMinReq && !reqRev |->
      lim.revLim == secondLim_q)
    else $error("selector 5 idle reverse wrong");
  min_req_rev_a: assert property ( // RULE8 RULE11
      active && lim.sel == tls_pkg::SelMinReq && reqRev |->
      lim.revLim <= negLim_q && lim.revLim <= secondLim_q
      && (lim.revLim == negLim_q || lim.revLim == secondLim_q))
    else $error("selector 5 active reverse wrong");
  net_fwd_a: assert property ( // RULE9
      active && lim.sel == tls_pkg::SelNetReq && reqFwd |->
      lim.fwdLim == netFwdLim_q)
    else $error("selector 6 forward wrong");
  net_rev_idle_a: assert property ( // RULE9 RULE11
      active && lim.sel == tls_pkg::SelNetReq && !reqRev |->
      lim.revLim <= negLim_q && lim.revLim <= secondLim_q
      && (lim.revLim == negLim_q || lim.revLim == secondLim_q))
    else $error("selector 6 idle reverse wrong");
  obj_fwd_a: assert property ( // RULE9
      active && lim.sel == tls_pkg::SelObjReq && reqFwd |->
      lim.fwdLim == firstLim_q)
    else $error("selector 7 forward request wrong");
  obj_rev_a: assert property ( // RULE9
      active && lim.sel == tls_pkg::SelObjReq && reqRev |->
      lim.revLim == secondLim_q)
    else $error("selector 7 reverse request wrong");
  sel_write_a: assert property (wrSel |=> sel_q == $past(pwdata[2:0])) // RULE3
    else $error("selector write lost");
  sel_hold_a: assert property (!wrSel |=> $stable(sel_q)) // RULE3
    else $error("selector changed without write");
  refused_write_a: assert property (pslverr && pwrite |=> // RULE3
      $stable(sel_q) && $stable(ctrl_q) && $stable(firstLim_q))
    else $error("refused write changed state");
  limit_cap_a: assert property (wrFirst |=>                             // RULE13
      firstLim_q <= MaxLimit && ($past(pwdata[LimW-1:0]) > MaxLimit
      || firstLim_q == $past(pwdata[LimW-1:0])))
    else $error("limit write not capped");
  second_cap_a: assert property (wrSecond |=> // RULE12 RULE13
      secondLim_q == ($past(pwdata[LimW-1:0]) > MaxLimit
      ? MaxLimit : $past(pwdata[LimW-1:0])))
    else $error("second limit write wrong");
  pos_cap_a: assert property (wrPos |=> // RULE12 RULE13
      posLim_q == ($past(pwdata[LimW-1:0]) > MaxLimit
      ? MaxLimit : $past(pwdata[LimW-1:0])))
    else $error("positive limit write wrong");
  fwd_clamp_a: assert property (overFwd |=>                             // RULE14
      torqueOut == $past(lim.fwdLim))
    else $error("forward clamp wrong");
  rev_clamp_a: assert property (overRev |=>                             // RULE14
      torqueOut == LimW'(-$past(lim.revLim)))
    else $error("reverse clamp wrong");
  pass_through_a: assert property (!overFwd && !overRev |=> // RULE14
      torqueOut == $past(torqueCmd))
    else $error("unclamped torque altered");

  swap_req_c: cover property (active && sel_q == 3'h3 && reqFwd);
  min_req_c: cover property (active && sel_q == 3'h5 && reqRev);
  clamp_c: cover property (overFwd ##1 overRev);
  sel_err_c: cover property (access && pwrite && hitSel && selBad);
  net_req_c: cover property (active && sel_q == 3'h6 && reqFwd);
endmodule

// ===== verification/tls_host_model.sv
// host controller model: apb master reaching the limit objects
module tls_host_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [19:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 20'h00000;
    pwdata = 32'h0000_0000;
  end

  // one transfer; request held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [tls_pkg::IdxW-1:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, tls_pkg::AlignZero};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
  endtask
endmodule

// ===== verification/testbench.sv
// self-checking bench for the torque limit selector
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MaxLim = 16'h00E1;
  typedef struct packed {
    logic [2:0]  sel;
    logic [3:0]  req;
    logic [15:0] expF;
    logic [15:0] expR;
  } tls_row_t;
  // req bits: forward pin, reverse pin, net forward, net reverse
  localparam tls_row_t Rows[18] = '{
    {3'h0, 4'h0, 16'h0064, 16'h0064}, {3'h0, 4'h8, 16'h0064, 16'h0064},
    {3'h1, 4'h1, 16'h0064, 16'h0064}, {3'h2, 4'h0, 16'h0064, 16'h0050},
    {3'h2, 4'hC, 16'h0064, 16'h0050}, {3'h3, 4'h0, 16'h0064, 16'h0064},
    {3'h3, 4'h9, 16'h0050, 16'h0050}, {3'h3, 4'h2, 16'h0050, 16'h0064},
    {3'h4, 4'h0, 16'h005A, 16'h0046}, {3'h4, 4'hF, 16'h005A, 16'h0046},
    {3'h5, 4'h0, 16'h0064, 16'h0050}, {3'h5, 4'h4, 16'h0064, 16'h0046},
    {3'h5, 4'h2, 16'h005A, 16'h0050}, {3'h6, 4'h0, 16'h005A, 16'h0046},
    {3'h6, 4'h8, 16'h003C, 16'h0046}, {3'h6, 4'h5, 16'h005A, 16'h0032},
    {3'h7, 4'h0, 16'h003C, 16'h0032}, {3'h7, 4'h3, 16'h0064, 16'h0050}};
  localparam logic [17:0] LimIdx[6] = '{tls_pkg::IdxFirstLim,
    tls_pkg::IdxSecondLim, tls_pkg::IdxNetFwdLim, tls_pkg::IdxNetRevLim,
    tls_pkg::IdxPosLim, tls_pkg::IdxNegLim};
  localparam logic [31:0] LimVal[6] = '{32'h0000_0064, 32'h0000_0050,
    32'h0000_003C, 32'h0000_0032, 32'h0000_005A, 32'h0000_0046};

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, fwdPin, revPin;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] torqueCmd, torqueOut;
  logic        err;
  int          n_fail = 0;
  int          n_compared = 0;

  always #20 clk = ~clk;

  tls_host_model host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  tls_top #(.AddrW(20), .MaxLimit(MaxLim)) uut (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fwdExtLimitIn(fwdPin), .revExtLimitIn(revPin),
    .torqueCmd(torqueCmd), .torqueOut(torqueOut));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [17:0] idx, input logic [31:0] val);
    host.xfer(1'b1, idx, val, rdat, err);
    check("wrErr", {31'h0, err}, 32'h0000_0000);
  endtask

  task automatic rdChk(input string what, input logic [17:0] idx,
                       input logic [31:0] exp);
    host.xfer(1'b0, idx, 32'h0000_0000, rdat, err);
    check("rdErr", {31'h0, err}, 32'h0000_0000);
    check(what, rdat, exp);
  endtask

  task automatic trq(input logic [15:0] cmd, input logic [15:0] exp);
    @(posedge clk);
    torqueCmd <= cmd;
    repeat (2) @(posedge clk);
    check("torqueOut", {16'h0000, torqueOut}, {16'h0000, exp});
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run;
  end

  initial begin
    fwdPin = 1'b0;
    revPin = 1'b0;
    torqueCmd = 16'h0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("torqueOutReset", {16'h0000, torqueOut}, 32'h0000_0000);
    foreach (LimIdx[i])
      rdChk("limitReset", LimIdx[i], {16'h0000, MaxLim});
    rdChk("selReset", tls_pkg::IdxMethodSel, 32'h0000_0000);
    rdChk("ctrlReset", tls_pkg::IdxControl, 32'h0000_0000);
    foreach (LimIdx[i]) wr(LimIdx[i], LimVal[i]);
    foreach (Rows[i]) begin
      wr(tls_pkg::IdxMethodSel, {29'h0, Rows[i].sel});
      wr(tls_pkg::IdxControl,
         {30'h0, Rows[i].req[0], Rows[i].req[1]} | 32'h14);
      @(posedge clk);
      fwdPin <= Rows[i].req[3];
      revPin <= Rows[i].req[2];
      rdChk("fwdLim", tls_pkg::IdxFwdActive,
            {16'h0, Rows[i].expF});
      rdChk("revLim", tls_pkg::IdxRevActive,
            {16'h0, Rows[i].expR});
      trq(16'h0190, Rows[i].expF);
      trq(16'hFE70, 16'h0000 - Rows[i].expR);
    end
    // selector 3 with both requests on: limits move only when active
    @(posedge clk);
    fwdPin <= 1'b0;
    revPin <= 1'b0;
    wr(tls_pkg::IdxMethodSel, 32'h0000_0003);
    wr(tls_pkg::IdxControl, 32'h0000_0013);
    rdChk("fwdServoOff", tls_pkg::IdxFwdActive, 32'h0000_0064);
    rdChk("statServoOff", tls_pkg::IdxStatus,
          32'h0000_0006);
    for (int m = 0; m < 6; m++) begin
      wr(tls_pkg::IdxControl, 32'h0000_0007 | (m << 4));
      rdChk("fwdMode", tls_pkg::IdxFwdActive,
            (m >= 1 && m <= 4) ? 32'h0000_0050 : 32'h0000_0064);
      rdChk("statMode", tls_pkg::IdxStatus,
            (m >= 1 && m <= 4) ? 32'h0000_0007 : 32'h0000_0006);
    end
    trq(16'hFFE2, 16'hFFE2);
    host.xfer(1'b1, tls_pkg::IdxMethodSel, 32'h0000_0008, rdat, err);
    check("selRefused", {31'h0, err}, 32'h0000_0001);
    rdChk("selKept", tls_pkg::IdxMethodSel, 32'h0000_0003);
    host.xfer(1'b1, tls_pkg::IdxStatus, 32'h0000_0000, rdat, err);
    check("roRefused", {31'h0, err}, 32'h0000_0001);
    host.xfer(1'b0, 18'h00200, 32'h0000_0000, rdat, err);
    check("unmappedErr", {31'h0, err}, 32'h0000_0001);
    check("unmappedData", rdat, 32'h0000_0000);
    wr(tls_pkg::IdxFirstLim, 32'h0000_012C);
    rdChk("limitSat", tls_pkg::IdxFirstLim, {16'h0000, MaxLim});
    wr(tls_pkg::IdxFirstLim, 32'h0000_0000);
    wr(tls_pkg::IdxMethodSel, 32'h0000_0000);
    rdChk("limitZero", tls_pkg::IdxFirstLim, 32'h0000_0000);
    trq(16'h0190, 16'h0000);
    // reset in mid-run restores the ceiling
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdChk("limitMidReset", tls_pkg::IdxFirstLim, {16'h0000, MaxLim});
    rdChk("selMidReset", tls_pkg::IdxMethodSel, 32'h0000_0000);
    trq(16'h0190, MaxLim);
    complete_run;
  end
endmodule
